// ===== rtl/mfs_regs.vh
`ifndef MFS_REGS_VH
`define MFS_REGS_VH
// ==========================================
// Register offsets (byte addresses).
`define MFS_CTRL_OFF 12'h000
`define MFS_ENABLE_OFF 12'h004
`define MFS_CLEAR_OFF 12'h008
`define MFS_LIVE_OFF 12'h00c
`define MFS_STICKY_OFF 12'h010
`define MFS_IMAX_OFF 12'h014
`define MFS_ULOW_OFF 12'h018
`define MFS_UHIGH_OFF 12'h01c
`define MFS_NOVER_OFF 12'h020
`define MFS_EBLOCK_OFF 12'h024
`define MFS_EPER_OFF 12'h028
// ==========================================
// Fault bit positions.
`define MFS_F_OC 0
`define MFS_F_UV 1
`define MFS_F_OV 2
`define MFS_F_OL 3
`define MFS_F_OS 4
`define MFS_F_BR 5
`define MFS_NFAULT 6
// ==========================================
// Reset values.
`define MFS_ENABLE_RST 6'h3e
`define MFS_THR_RST 16'hffff
`define MFS_ULOW_RST 16'h0000
`define MFS_EPER_RST 16'h0010
`endif

// ===== rtl/mfs_fault_supervisor.v
`timescale 1ns/100ps
// How it works
// R01: Live bit 0 is set while bus current is above the current limit.
// R02: While overcurrent is live, all PWM enables are forced off.
// R03: Live bit 1 is set while bus voltage is below the low voltage limit.
// R04: Live bit 2 is set while bus voltage is above the high voltage limit.
// R05: Live bit 3 is set while the overload input is true.
// R06: Live bit 4 is set while speed exceeds the overspeed limit.
// R07: Live bit 5 is set once back-EMF stays below its limit longer than the blocked duration.
// R08: Each live bit follows its condition and drops as soon as the condition is gone.
// R09: A live bit that is set also sets its sticky bit, which stays after the condition goes.
// R10: Writing 1 to the clear request clears every sticky bit whose fault is not indicated; only this and reset clear them.
// R11: Each sticky bit is also given as its own output.
// R12: A fault enable of 0 suppresses that fault's indication and 1 restores it.
// R13: Overcurrent has no enable and is always indicated.
// R14: Any indicated fault asks the drive state machine to enter its fault state.
// R15: Drive on sets all PWM enables and drive off clears them.
// R16: Reset clears live, sticky and clear request, and sets all enables.
// R17: The blocked duration counter steps once per control period while back-EMF is low, else resets.
`include "mfs_regs.vh"
module mfs_fault_supervisor #(
    parameter DW = 16,
    parameter NPWM = 6
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire ctrl_tick,
    input wire [DW-1:0] bus_current,
    input wire [DW-1:0] bus_voltage,
    input wire [DW-1:0] rotor_speed,
    input wire [DW-1:0] bemf_level,
    input wire overload_in,
    output reg [NPWM-1:0] pwm_enable,
    output reg fault_state_req,
    output reg [`MFS_NFAULT-1:0] live_fault_vector,
    output reg [`MFS_NFAULT-1:0] sticky_fault_vector,
    output reg sticky_oc,
    output reg sticky_uv,
    output reg sticky_ov,
    output reg sticky_ol,
    output reg sticky_os,
    output reg sticky_br
);
// ==========================================
// Register file.
reg drive_on_off_q;
reg [`MFS_NFAULT-1:0] fault_type_enable_q;
reg sticky_fault_clear_req_q;
reg [DW-1:0] imax_q;
reg [DW-1:0] bus_low_voltage_limit_q;
reg [DW-1:0] bus_high_voltage_limit_q;
reg [DW-1:0] nover_q;
reg [DW-1:0] eblock_q;
reg [15:0] eper_q;
reg [15:0] br_cnt_q;
reg pready_q;
wire wr_en;
wire rd_en;
wire addr_ok;
assign wr_en = psel & penable & pwrite & pready_q;
assign rd_en = psel & ~penable & ~pwrite;
assign pready = pready_q;
assign pslverr = 1'b0;
assign addr_ok = (paddr <= `MFS_EPER_OFF) && (paddr[1:0] == 2'b00);
// Answer one cycle into the access phase so that outputs stay registered.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready_q <= 1'b0;
    end else begin
        pready_q <= psel & penable & ~pready_q;
    end
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        drive_on_off_q <= 1'b0;
        fault_type_enable_q <= `MFS_ENABLE_RST; // R16
        sticky_fault_clear_req_q <= 1'b0; // R16
        imax_q <= `MFS_THR_RST;
        bus_low_voltage_limit_q <= `MFS_ULOW_RST;
        bus_high_voltage_limit_q <= `MFS_THR_RST;
        nover_q <= `MFS_THR_RST;
        eblock_q <= `MFS_ULOW_RST;
        eper_q <= `MFS_EPER_RST;
    end else begin
        sticky_fault_clear_req_q <= 1'b0;
        if (wr_en) begin
            case (paddr)
                `MFS_CTRL_OFF: begin
                    drive_on_off_q <= pwdata[0];
                end
                `MFS_ENABLE_OFF: begin
                    fault_type_enable_q <= {pwdata[`MFS_NFAULT-1:1], 1'b0}; // R12 R13
                end
                `MFS_CLEAR_OFF: begin
                    sticky_fault_clear_req_q <= pwdata[0]; // R10
                end
                `MFS_IMAX_OFF: begin
                    imax_q <= pwdata[DW-1:0];
                end
                `MFS_ULOW_OFF: begin
                    bus_low_voltage_limit_q <= pwdata[DW-1:0];
                end
                `MFS_UHIGH_OFF: begin
                    bus_high_voltage_limit_q <= pwdata[DW-1:0];
                end
                `MFS_NOVER_OFF: begin
                    nover_q <= pwdata[DW-1:0];
                end
                `MFS_EBLOCK_OFF: begin
                    eblock_q <= pwdata[DW-1:0];
                end
                `MFS_EPER_OFF: begin
                    eper_q <= pwdata[15:0];
                end
                default: begin
                end
            endcase
        end
    end
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0000_0000;
    end else if (rd_en) begin
        case (paddr)
            `MFS_CTRL_OFF: prdata <= {31'h0, drive_on_off_q};
            `MFS_ENABLE_OFF: prdata <= {26'h0, fault_type_enable_q};
            `MFS_CLEAR_OFF: prdata <= {31'h0, sticky_fault_clear_req_q};
            `MFS_LIVE_OFF: prdata <= {26'h0, live_fault_vector};
            `MFS_STICKY_OFF: prdata <= {26'h0, sticky_fault_vector};
            `MFS_IMAX_OFF: prdata <= {{(32-DW){1'b0}}, imax_q};
            `MFS_ULOW_OFF: prdata <= {{(32-DW){1'b0}}, bus_low_voltage_limit_q};
            `MFS_UHIGH_OFF: prdata <= {{(32-DW){1'b0}}, bus_high_voltage_limit_q};
            `MFS_NOVER_OFF: prdata <= {{(32-DW){1'b0}}, nover_q};
            `MFS_EBLOCK_OFF: prdata <= {{(32-DW){1'b0}}, eblock_q};
            `MFS_EPER_OFF: prdata <= {16'h0, eper_q};
            default: prdata <= 32'h0000_0000;
        endcase
    end
end
// ==========================================
// Input synchronisers; measurements arrive from the front end's own timing.
reg [DW-1:0] cur_s1, cur_s2, vol_s1, vol_s2, spd_s1, spd_s2, bemf_s1, bemf_s2;
reg ol_s1, ol_s2, tick_s1, tick_s2, tick_s3;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cur_s1 <= {DW{1'b0}};
        cur_s2 <= {DW{1'b0}};
        vol_s1 <= {DW{1'b0}};
        vol_s2 <= {DW{1'b0}};
        spd_s1 <= {DW{1'b0}};
        spd_s2 <= {DW{1'b0}};
        bemf_s1 <= {DW{1'b0}};
        bemf_s2 <= {DW{1'b0}};
        ol_s1 <= 1'b0;
        ol_s2 <= 1'b0;
        tick_s1 <= 1'b0;
        tick_s2 <= 1'b0;
        tick_s3 <= 1'b0;
    end else begin
        cur_s1 <= bus_current;
        cur_s2 <= cur_s1;
        vol_s1 <= bus_voltage;
        vol_s2 <= vol_s1;
        spd_s1 <= rotor_speed;
        spd_s2 <= spd_s1;
        bemf_s1 <= bemf_level;
        bemf_s2 <= bemf_s1;
        ol_s1 <= overload_in;
        ol_s2 <= ol_s1;
        tick_s1 <= ctrl_tick;
        tick_s2 <= tick_s1;
        tick_s3 <= tick_s2;
    end
end
// A multi-bit value may be caught mid-change for one cycle; the front end should hold it steady.
wire tick_rise;
assign tick_rise = tick_s2 & ~tick_s3;
// ==========================================
// Fault detection.
wire bemf_low;
assign bemf_low = bemf_s2 < eblock_q;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        br_cnt_q <= 16'h0000;
    end else if (!bemf_low) begin
        br_cnt_q <= 16'h0000; // R17
    end else if (tick_rise && br_cnt_q != 16'hffff) begin
        br_cnt_q <= br_cnt_q + 16'h0001; // R17
    end
end
wire [`MFS_NFAULT-1:0] cond;
assign cond[`MFS_F_OC] = cur_s2 > imax_q; // R01
assign cond[`MFS_F_UV] = vol_s2 < bus_low_voltage_limit_q; // R03
assign cond[`MFS_F_OV] = vol_s2 > bus_high_voltage_limit_q; // R04
assign cond[`MFS_F_OL] = ol_s2; // R05
assign cond[`MFS_F_OS] = spd_s2 > nover_q; // R06
assign cond[`MFS_F_BR] = bemf_low && (br_cnt_q > eper_q); // R07
wire [`MFS_NFAULT-1:0] shown;
assign shown = cond & (fault_type_enable_q | 6'h01); // R12 R13
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        live_fault_vector <= 6'h00; // R16
        sticky_fault_vector <= 6'h00; // R16
        fault_state_req <= 1'b0;
        pwm_enable <= {NPWM{1'b0}};
        sticky_oc <= 1'b0;
        sticky_uv <= 1'b0;
        sticky_ov <= 1'b0;
        sticky_ol <= 1'b0;
        sticky_os <= 1'b0;
        sticky_br <= 1'b0;
    end else begin
        live_fault_vector <= shown; // R08
        // Set wins over clear so a fault arriving with the clear is kept.
        sticky_fault_vector <= (sticky_fault_clear_req_q ? 6'h00 : sticky_fault_vector) | shown; // R09 R10
        {sticky_br, sticky_os, sticky_ol, sticky_ov, sticky_uv, sticky_oc} <=
            (sticky_fault_clear_req_q ? 6'h00 : sticky_fault_vector) | shown; // R11
        fault_state_req <= |shown; // R14
        pwm_enable <= (drive_on_off_q && !cond[`MFS_F_OC]) ? {NPWM{1'b1}} : {NPWM{1'b0}}; // R02 R15
    end
end
endmodule

// ===== sim/mfs_fault_supervisor_properties.sv
`timescale 1ns/100ps
// ==========
// Fault supervisor checker.
module mfs_fault_supervisor_properties #(parameter DW = 16, parameter NPWM = 6) (
    input wire pclk, input wire presetn, input wire psel, input wire penable,
    input wire pwrite, input wire pready, input wire [11:0] paddr, input wire [31:0] pwdata,
    input wire [DW-1:0] bus_current, input wire overload_in, input wire fault_state_req,
    input wire [NPWM-1:0] pwm_enable, input wire [5:0] live_fault_vector, input wire [5:0] sticky_fault_vector,
    input wire sticky_oc, input wire sticky_uv, input wire sticky_ov, input wire sticky_ol,
    input wire sticky_os, input wire sticky_br
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [5:0] lv = live_fault_vector;
    wire [5:0] sv = sticky_fault_vector;
    wire clr_wr = psel && penable && pready && pwrite && paddr == 12'h008 && pwdata[0];
    // Inputs pass two sync stages first, so a cause shows in the live bits three edges later.
    sequence s_ol_off; !overload_in ##3 1'b1; endsequence
    sequence s_cur_zero; bus_current == 0 ##3 1'b1; endsequence
    a_sticky_mirror: assert property (sv == {sticky_br, sticky_os, sticky_ol, sticky_ov, sticky_uv, sticky_oc})
        else $error("sticky outputs differ");
    a_live_sticky: assert property ((lv & ~sv) == 6'h00)
        else $error("live bit without sticky bit");
    a_sticky_hold: assert property ((($past(sv) & ~sv) != 6'h00) |-> $past(clr_wr) || $past(clr_wr, 2))
        else $error("sticky bit dropped without clear");
    a_req_or: assert property (fault_state_req == |lv)
        else $error("fault state request wrong");
    a_oc_pwm: assert property (lv[0] |-> pwm_enable == 0)
        else $error("pwm on during overcurrent");
    a_pwm_all: assert property (pwm_enable == 0 || &pwm_enable)
        else $error("pwm enables split");
    a_ol_quiet: assert property (s_ol_off |-> !lv[3])
        else $error("overload bit without cause");
    a_oc_quiet: assert property (s_cur_zero |-> !lv[0])
        else $error("overcurrent bit without cause");
    a_reset_clear: assert property (!$past(presetn) |-> lv == 0 && sv == 0 && !fault_state_req)
        else $error("faults not clear after reset");
endmodule

// ===== sim/mfs_front_end.sv
`timescale 1ns/100ps
// ==========
// Measurement front end and control tick.
module mfs_front_end (
    input wire pclk,
    output logic [15:0] bus_current,
    output logic [15:0] bus_voltage,
    output logic [15:0] rotor_speed,
    output logic [15:0] bemf_level,
    output logic overload_in,
    output logic ctrl_tick
);
    logic [2:0] cnt = 3'h0;
    initial begin
        {bus_current, bus_voltage, rotor_speed, bemf_level} = {16'h0000, 16'h0400, 16'h0010, 16'h1000};
        overload_in = 1'b0;
        ctrl_tick = 1'b0;
    end
    // The tick runs free with period eight, so blocked rotor counts stay slow enough to watch.
    always @(posedge pclk) begin
        cnt <= cnt + 3'h1;
        ctrl_tick <= cnt[2];
    end
    task set(input logic [15:0] c, v, s, e, input logic o);
        @(posedge pclk);
        {bus_current, bus_voltage, rotor_speed, bemf_level} <= {c, v, s, e};
        overload_in <= o;
    endtask
endmodule

// ===== sim/mfs_fault_supervisor_bench.sv
`timescale 1ns/100ps
`include "mfs_regs.vh"
// ==========
// Fault supervisor bench.
module mfs_fault_supervisor_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rd;
    int n_fail = 0;
    int comparisons = 0;
    wire [31:0] prdata;
    wire pready, ctrl_tick, overload_in, fault_state_req;
    wire [15:0] bus_current, bus_voltage, rotor_speed, bemf_level;
    wire [5:0] pwm_enable, live, sticky, sb;
    logic [15:0] tc[6] = '{16'h0201, 16'h0200, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] tv[6] = '{16'h0400, 16'h0100, 16'h00ff, 16'h0801, 16'h0400, 16'h0400};
    logic [15:0] ts[6] = '{16'h0010, 16'h0400, 16'h0010, 16'h0010, 16'h0010, 16'h0401};
    logic [5:0] te[6] = '{6'h01, 6'h00, 6'h02, 6'h04, 6'h08, 6'h10};
    mfs_fault_supervisor i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(), .ctrl_tick(ctrl_tick),
        .bus_current(bus_current), .bus_voltage(bus_voltage), .rotor_speed(rotor_speed), .bemf_level(bemf_level),
        .overload_in(overload_in), .pwm_enable(pwm_enable), .fault_state_req(fault_state_req),
        .live_fault_vector(live), .sticky_fault_vector(sticky), .sticky_oc(sb[0]), .sticky_uv(sb[1]),
        .sticky_ov(sb[2]), .sticky_ol(sb[3]), .sticky_os(sb[4]), .sticky_br(sb[5]));
    mfs_front_end u_fe (.pclk(pclk), .bus_current(bus_current), .bus_voltage(bus_voltage), .rotor_speed(rotor_speed),
        .bemf_level(bemf_level), .overload_in(overload_in), .ctrl_tick(ctrl_tick));
    initial begin
        forever #2 pclk = ~pclk;
    end
    initial begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        results();
    end
    task results;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Ready is read right after each rising edge, before the design's updates land, so it is the sampled value.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task wt(input int n);
        repeat (n) @(negedge pclk);
    endtask
    task nom(input logic [15:0] e);
        u_fe.set(16'h0000, 16'h0400, 16'h0010, e, 1'b0);
    endtask
    task t_reset;
        apb(1'b0, `MFS_ENABLE_OFF, 32'h0);
        chk("enable", 32'h3e, rd);
        apb(1'b0, 12'h03c, 32'h0);
        chk("unmapped", 32'h0, rd);
        apb(1'b0, `MFS_STICKY_OFF, 32'h0);
        chk("sticky", 32'h0, rd);
        apb(1'b1, `MFS_CTRL_OFF, 32'h1);
        wt(2);
        chk("pwm", 6'h3f, pwm_enable);
    endtask
    task t_faults;
        apb(1'b1, `MFS_IMAX_OFF, 32'h200);
        apb(1'b1, `MFS_ULOW_OFF, 32'h100);
        apb(1'b1, `MFS_UHIGH_OFF, 32'h800);
        apb(1'b1, `MFS_NOVER_OFF, 32'h400);
        for (int i = 0; i < 6; i++) begin
            u_fe.set(tc[i], tv[i], ts[i], 16'h1000, te[i] == 6'h08);
            wt(5);
            chk("live", te[i], live);
            chk("req", |te[i], fault_state_req);
            chk("pwm", te[i] == 6'h01 ? 6'h00 : 6'h3f, pwm_enable);
            apb(1'b0, `MFS_LIVE_OFF, 32'h0);
            chk("live reg", te[i], rd);
            nom(16'h1000);
            wt(5);
            chk("live", 6'h00, live);
            chk("sticky", te[i], sticky);
            chk("sticky bits", te[i], sb);
            apb(1'b1, `MFS_CLEAR_OFF, 32'h1);
            wt(2);
            chk("sticky", 6'h00, sticky);
            chk("sticky bits", 6'h00, sb);
        end
    endtask
    task t_mask;
        apb(1'b1, `MFS_ENABLE_OFF, 32'h0);
        u_fe.set(16'h0201, 16'h00ff, 16'h0010, 16'h1000, 1'b0);
        wt(5);
        chk("live", 6'h01, live);
        apb(1'b1, `MFS_ENABLE_OFF, 32'h3e);
        wt(5);
        chk("live", 6'h03, live);
        nom(16'h1000);
        apb(1'b1, `MFS_CLEAR_OFF, 32'h1);
        apb(1'b1, `MFS_CTRL_OFF, 32'h0);
        wt(2);
        chk("pwm", 6'h00, pwm_enable);
    endtask
    task t_blocked;
        apb(1'b1, `MFS_EBLOCK_OFF, 32'h100);
        apb(1'b1, `MFS_EPER_OFF, 32'h2);
        nom(16'h0010);
        wt(12);
        chk("live", 6'h00, live);
        wt(30);
        chk("live", 6'h20, live);
        nom(16'h1000);
        wt(5);
        chk("live", 6'h00, live);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_faults();
        t_mask();
        t_blocked();
        results();
    end
endmodule
bind mfs_fault_supervisor mfs_fault_supervisor_properties #(.DW(DW), .NPWM(NPWM)) u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr),
    .pwdata(pwdata), .bus_current(bus_current), .overload_in(overload_in), .fault_state_req(fault_state_req),
    .pwm_enable(pwm_enable), .live_fault_vector(live_fault_vector), .sticky_fault_vector(sticky_fault_vector),
    .sticky_oc(sticky_oc), .sticky_uv(sticky_uv), .sticky_ov(sticky_ov), .sticky_ol(sticky_ol),
    .sticky_os(sticky_os), .sticky_br(sticky_br));
